// ---- inc/adccs_pkg.sv ----
// Purpose: constants and types of the sensor front end control/status block
// Assumes: byte-wide register port, one clock
// Notes:   reserved bits read as zero
// Summary of operation
// - bit 0 enables serial reset, default off
// - serial reset register locks after first write
// - full reset clears register and its lock
// - power write codes active, down, stand-by
// - power read shows mode in effect
// - restart bit abandons conversion, starts new
// - policy bit lets full reset restore calibration
// - bypass bit stops external clock detection
// - clock select acts only while bypassed
// - current code 0 to 0xa, 100 uA steps
// - available byte 0xff none, else ready
// - 24-bit result, high byte first at 0x1a
// - status bit 1 flags pending scan update
// - status bit 0 flags stale or repeat read
// - only code 0xc3 triggers full reset
package adccs_pkg;
  localparam int BYTE_W = 8;  // register width
  localparam int RES_W  = 24; // conversion result width
  localparam int PWR_W  = 2;  // power field width
  localparam int CUR_W  = 4;  // excitation code width

  // register offsets
  localparam logic [7:0] ADDR_RESET_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SER_RESET  = 8'h02;
  localparam logic [7:0] ADDR_POWER      = 8'h08;
  localparam logic [7:0] ADDR_RESTART    = 8'h0b;
  localparam logic [7:0] ADDR_AUX        = 8'h12;
  localparam logic [7:0] ADDR_AVAIL      = 8'h18;
  localparam logic [7:0] ADDR_RES_HI     = 8'h1a;
  localparam logic [7:0] ADDR_RES_MID    = 8'h1b;
  localparam logic [7:0] ADDR_RES_LO     = 8'h1c;
  localparam logic [7:0] ADDR_CHAN_STAT  = 8'h1e;

  // codes
  localparam logic [7:0] FULL_RESET_CODE = 8'hc3;
  localparam logic [7:0] AVAIL_NONE      = 8'hff;
  localparam logic [7:0] AVAIL_READY     = 8'h00;
  localparam logic [1:0] PWR_ACTIVE      = 2'h0;
  localparam logic [1:0] PWR_DOWN        = 2'h1;
  localparam logic [1:0] PWR_UNDEF       = 2'h2;
  localparam logic [1:0] PWR_STANDBY     = 2'h3;
  localparam logic [3:0] CUR_CODE_MAX    = 4'ha;

  // field positions
  localparam int SPI_EN_BIT      = 0;
  localparam int PWR_LSB         = 0;
  localparam int RESTART_BIT     = 0;
  localparam int AUX_CAL_BIT     = 6;
  localparam int AUX_BYPASS_BIT  = 5;
  localparam int AUX_CLKSEL_BIT  = 4;
  localparam int AUX_CUR_LSB     = 0;
  localparam int STS_PENDING_BIT = 1;
  localparam int STS_STALE_BIT   = 0;
  localparam int RES_HI_LSB      = 16;
  localparam int RES_MID_LSB     = 8;
  localparam int RES_LO_LSB      = 0;
  localparam logic [1:0] IDX_HI  = 2'h0;
  localparam logic [1:0] IDX_MID = 2'h1;
  localparam logic [1:0] IDX_LO  = 2'h2;

  // one register access from the serial port logic
  typedef struct packed {
    logic       wr;    // write strobe
    logic       rd;    // read strobe
    logic [7:0] addr;  // register offset
    logic [7:0] wdata; // write byte
  } adccs_req_t;

  // all state of the block
  typedef struct packed {
    logic             spi_en;    // serial reset enable
    logic             spi_lock;  // sticky after first write
    logic [PWR_W-1:0] pwr_req;   // requested power mode
    logic [PWR_W-1:0] pwr_now;   // mode in effect
    logic             aux_cal;   // calibration reset policy
    logic             aux_byp;   // clock detect bypass
    logic             aux_sel;   // clock select
    logic             clk_ext;   // effective external clock
    logic [CUR_W-1:0] cur_code;  // excitation current code
    logic             avail;     // unread result present
    logic [RES_W-1:0] result;    // latched result
    logic [2:0]       read_mask; // bytes already read
    logic             stale;     // last result read stale
    logic [7:0]       rdata;     // read answer
    logic             rd_valid;  // read answer strobe
    logic             restart;   // restart pulse
    logic             full_rst;  // full reset pulse
    logic             cal_rst;   // calibration reset pulse
  } adccs_state_t;

  localparam adccs_state_t STATE_RESET = '0;
endpackage

// ---- hw/adccs_regs.sv ----
// Purpose: control and status registers of the sensor front end
// Assumes: serial framing decoded outside, one access per cycle
// Notes:   all outputs are flops of one state struct
`timescale 1ns/100ps
`default_nettype none
module adccs_regs (
  input  wire logic                         core_clk,            // 200 MHz
  input  wire logic                         rst_n,               // sync reset
  input  wire logic                         clk_en,              // freeze when low
  input  wire adccs_pkg::adccs_req_t        host_req,            // register access
  output logic [adccs_pkg::BYTE_W-1:0]      rd_data,             // read byte
  output logic                              rd_valid,            // read strobe
  input  wire logic                         conv_done,           // result pulse
  input  wire logic [adccs_pkg::RES_W-1:0]  conv_result,         // result word
  input  wire logic                         power_ack,           // mode applied
  input  wire logic                         scan_update_pending, // scan busy
  output logic                              serial_reset_enable, // serial reset on
  output logic [adccs_pkg::PWR_W-1:0]       power_mode_req,      // requested mode
  output logic                              conversion_restart,  // restart pulse
  output logic                              full_reset_pulse,    // full reset
  output logic                              calibration_reset,   // coeff restore
  output logic                              clock_detect_bypass, // detect off
  output logic                              clock_select_ext,    // ext clock
  output logic [adccs_pkg::CUR_W-1:0]       excitation_current_code // current
);
  import adccs_pkg::*;

  adccs_state_t st;      // registered state
  adccs_state_t next_st; // next state
  logic [7:0]   rd_byte; // read mux output
  logic         res_hit; // result byte addressed
  logic [1:0]   res_idx; // which result byte

  // write to a given offset this cycle
  function automatic logic wr_at(input adccs_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // read to a given offset this cycle
  function automatic logic rd_at(input adccs_req_t r, input logic [7:0] a);
    return r.rd && (r.addr == a);
  endfunction

  // read mux, address decode as an if chain
  always_comb begin
    rd_byte = '0;
    res_hit = 1'b0;
    res_idx = IDX_HI;
    if (host_req.addr == ADDR_SER_RESET) begin
      rd_byte[SPI_EN_BIT] = st.spi_en;
    end else if (host_req.addr == ADDR_POWER) begin
      // mode in effect, not the request
      rd_byte[PWR_LSB +: PWR_W] = st.pwr_now;
    end else if (host_req.addr == ADDR_AUX) begin
      rd_byte[AUX_CAL_BIT]            = st.aux_cal;
      rd_byte[AUX_BYPASS_BIT]         = st.aux_byp;
      rd_byte[AUX_CLKSEL_BIT]         = st.aux_sel;
      rd_byte[AUX_CUR_LSB +: CUR_W]   = st.cur_code;
    end else if (host_req.addr == ADDR_AVAIL) begin
      rd_byte = st.avail ? AVAIL_READY : AVAIL_NONE;
    end else if (host_req.addr == ADDR_RES_HI) begin
      rd_byte = st.result[RES_HI_LSB +: BYTE_W];
      res_hit = 1'b1;
      res_idx = IDX_HI;
    end else if (host_req.addr == ADDR_RES_MID) begin
      rd_byte = st.result[RES_MID_LSB +: BYTE_W];
      res_hit = 1'b1;
      res_idx = IDX_MID;
    end else if (host_req.addr == ADDR_RES_LO) begin
      rd_byte = st.result[RES_LO_LSB +: BYTE_W];
      res_hit = 1'b1;
      res_idx = IDX_LO;
    end else if (host_req.addr == ADDR_CHAN_STAT) begin
      // pending comes from the scan logic on this clock
      rd_byte[STS_PENDING_BIT] = scan_update_pending;
      rd_byte[STS_STALE_BIT]   = st.stale;
    end else begin
      // write-only and unmapped offsets read zero
      rd_byte = '0;
    end
  end

  // next state of the whole block
  always_comb begin
    next_st          = st;
    next_st.rd_valid = 1'b0;
    next_st.restart  = 1'b0;
    next_st.full_rst = 1'b0;
    next_st.cal_rst  = 1'b0;
    // power controller confirms the requested mode
    if (power_ack) begin
      next_st.pwr_now = st.pwr_req;
    end
    // register writes
    if (wr_at(host_req, ADDR_SER_RESET)) begin
      // first write lands, later ones bounce off
      if (!st.spi_lock) begin
        next_st.spi_en   = host_req.wdata[SPI_EN_BIT];
        next_st.spi_lock = 1'b1;
      end
    end else if (wr_at(host_req, ADDR_POWER)) begin
      // undefined code keeps the current request
      if (host_req.wdata[PWR_LSB +: PWR_W] != PWR_UNDEF) begin
        next_st.pwr_req = host_req.wdata[PWR_LSB +: PWR_W];
      end
    end else if (wr_at(host_req, ADDR_RESTART)) begin
      next_st.restart = host_req.wdata[RESTART_BIT];
    end else if (wr_at(host_req, ADDR_AUX)) begin
      next_st.aux_cal = host_req.wdata[AUX_CAL_BIT];
      next_st.aux_byp = host_req.wdata[AUX_BYPASS_BIT];
      next_st.aux_sel = host_req.wdata[AUX_CLKSEL_BIT];
      // codes past the top step would drive an unspecified current
      if (host_req.wdata[AUX_CUR_LSB +: CUR_W] <= CUR_CODE_MAX) begin
        next_st.cur_code = host_req.wdata[AUX_CUR_LSB +: CUR_W];
      end
    end
    // register reads
    if (host_req.rd) begin
      next_st.rd_valid = 1'b1;
      next_st.rdata    = rd_byte;
      if (res_hit) begin
        // stale when nothing new or this byte already seen
        next_st.stale = !st.avail || st.read_mask[res_idx];
        next_st.read_mask[res_idx] = 1'b1;
        // low byte closes the result
        if (res_idx == IDX_LO) begin
          next_st.avail = 1'b0;
        end
      end
    end
    // a new result beats a read that clears the old one
    if (conv_done) begin
      next_st.avail     = 1'b1;
      next_st.result    = conv_result;
      next_st.read_mask = '0;
    end
    // full reset overrides everything else in this cycle
    if (wr_at(host_req, ADDR_RESET_CTRL) &&
        (host_req.wdata == FULL_RESET_CODE)) begin
      next_st          = STATE_RESET;
      next_st.full_rst = 1'b1;
      // policy taken from the value before the reset
      next_st.cal_rst  = st.aux_cal;
    end
    // clock select only counts while detection is bypassed
    next_st.clk_ext = next_st.aux_byp && next_st.aux_sel;
  end

  // state register, frozen while clk_en is low
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= STATE_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign rd_data                 = st.rdata;
  assign rd_valid                = st.rd_valid;
  assign serial_reset_enable     = st.spi_en;
  assign power_mode_req          = st.pwr_req;
  assign conversion_restart      = st.restart;
  assign full_reset_pulse        = st.full_rst;
  assign calibration_reset       = st.cal_rst;
  assign clock_detect_bypass     = st.aux_byp;
  assign clock_select_ext        = st.clk_ext;
  assign excitation_current_code = st.cur_code;

  // checks, all on core_clk
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // full reset write taken this cycle
  logic take_full;
  assign take_full = clk_en && wr_at(host_req, ADDR_RESET_CTRL) &&
                     (host_req.wdata == FULL_RESET_CODE);

  // first write to the serial reset register lands
  property p_spi_first;
    clk_en && wr_at(host_req, ADDR_SER_RESET) && !st.spi_lock
      |=> serial_reset_enable == $past(host_req.wdata[SPI_EN_BIT]);
  endproperty
  a_spi_first: assert property (p_spi_first)
    else $error("serial reset enable not written");

  // locked register ignores later writes
  property p_spi_lock;
    clk_en && wr_at(host_req, ADDR_SER_RESET) && st.spi_lock
      |=> $stable(serial_reset_enable) && st.spi_lock;
  endproperty
  a_spi_lock: assert property (p_spi_lock)
    else $error("locked serial reset register changed");

  // full reset clears value and lock, pulses once
  property p_full_reset;
    take_full |=> !serial_reset_enable && !st.spi_lock &&
                  full_reset_pulse && (power_mode_req == PWR_ACTIVE);
  endproperty
  a_full_reset: assert property (p_full_reset)
    else $error("full reset did not clear registers");

  // other codes at the reset offset do nothing
  property p_reset_code;
    clk_en && wr_at(host_req, ADDR_RESET_CTRL) &&
    (host_req.wdata != FULL_RESET_CODE) |=> !full_reset_pulse;
  endproperty
  a_reset_code: assert property (p_reset_code)
    else $error("full reset from wrong code");

  // defined power codes become the request
  property p_pwr_write;
    clk_en && wr_at(host_req, ADDR_POWER) &&
    (host_req.wdata[PWR_LSB +: PWR_W] != PWR_UNDEF)
      |=> power_mode_req == $past(host_req.wdata[PWR_LSB +: PWR_W]);
  endproperty
  a_pwr_write: assert property (p_pwr_write)
    else $error("power request not taken");

  // undefined power code leaves request alone
  property p_pwr_undef;
    clk_en && wr_at(host_req, ADDR_POWER) &&
    (host_req.wdata[PWR_LSB +: PWR_W] == PWR_UNDEF) |=> $stable(power_mode_req);
  endproperty
  a_pwr_undef: assert property (p_pwr_undef)
    else $error("undefined power code changed mode");

  // power readback shows the mode in effect
  property p_pwr_read;
    clk_en && rd_at(host_req, ADDR_POWER) && !take_full
      |=> rd_valid && (rd_data[PWR_LSB +: PWR_W] == $past(st.pwr_now));
  endproperty
  a_pwr_read: assert property (p_pwr_read)
    else $error("power readback wrong");

  // restart bit gives exactly one pulse
  property p_restart;
    clk_en && wr_at(host_req, ADDR_RESTART) && host_req.wdata[RESTART_BIT]
      ##1 !(clk_en && wr_at(host_req, ADDR_RESTART)) && clk_en
      |-> conversion_restart ##1 !conversion_restart;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart pulse wrong");

  // calibration restore follows the policy bit
  property p_cal;
    take_full |=> calibration_reset == $past(st.aux_cal);
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration restore wrong");

  // external clock never chosen while detection runs
  property p_clksel;
    clock_select_ext |-> clock_detect_bypass;
  endproperty
  a_clksel: assert property (p_clksel)
    else $error("clock select acted without bypass");

  // available byte answers according to result state
  property p_avail;
    clk_en && rd_at(host_req, ADDR_AVAIL) && !take_full
      |=> rd_data == ($past(st.avail) ? AVAIL_READY : AVAIL_NONE);
  endproperty
  a_avail: assert property (p_avail)
    else $error("available byte wrong");

  // high byte returns bits 23 to 16 of the result
  property p_res_hi;
    clk_en && rd_at(host_req, ADDR_RES_HI) && !take_full
      |=> rd_data == $past(st.result[RES_HI_LSB +: BYTE_W]);
  endproperty
  a_res_hi: assert property (p_res_hi)
    else $error("result high byte wrong");

  // reading with nothing new marks the flag
  property p_stale;
    clk_en && host_req.rd && res_hit && !st.avail && !take_full
      |=> st.stale ##1 (st.stale || !clk_en || $past(host_req.rd) || $past(take_full));
  endproperty
  a_stale: assert property (p_stale)
    else $error("stale read not flagged");

  // pending input shows on status bit 1
  property p_pending;
    clk_en && rd_at(host_req, ADDR_CHAN_STAT) && !take_full
      |=> rd_data[STS_PENDING_BIT] == $past(scan_update_pending);
  endproperty
  a_pending: assert property (p_pending)
    else $error("scan pending bit wrong");

  // middle byte returns bits 15 to 8 of the result
  property p_res_mid;
    clk_en && rd_at(host_req, ADDR_RES_MID) && !take_full
      |=> rd_data == $past(st.result[RES_MID_LSB +: BYTE_W]);
  endproperty
  a_res_mid: assert property (p_res_mid)
    else $error("result middle byte wrong");

  // low byte returns bits 7 to 0 of the result
  property p_res_lo;
    clk_en && rd_at(host_req, ADDR_RES_LO) && !take_full
      |=> rd_data == $past(st.result[RES_LO_LSB +: BYTE_W]);
  endproperty
  a_res_lo: assert property (p_res_lo)
    else $error("result low byte wrong");

  // low byte read closes the result unless a new one lands
  property p_avail_clear;
    clk_en && rd_at(host_req, ADDR_RES_LO) && !conv_done |=> !st.avail;
  endproperty
  a_avail_clear: assert property (p_avail_clear)
    else $error("result still offered after low byte");

  // a new result is offered even against a clearing read
  property p_avail_set;
    clk_en && conv_done && !take_full
      |=> st.avail && (st.result == $past(conv_result));
  endproperty
  a_avail_set: assert property (p_avail_set)
    else $error("new result not offered");

  // first read of a byte of a new result is clean
  property p_fresh;
    clk_en && host_req.rd && res_hit && st.avail &&
    !st.read_mask[res_idx] && !take_full |=> !st.stale;
  endproperty
  a_fresh: assert property (p_fresh)
    else $error("fresh read flagged stale");

  // aux control bits follow the written byte
  property p_aux_write;
    clk_en && wr_at(host_req, ADDR_AUX)
      |=> clock_detect_bypass == $past(host_req.wdata[AUX_BYPASS_BIT]) &&
          st.aux_cal == $past(host_req.wdata[AUX_CAL_BIT]);
  endproperty
  a_aux_write: assert property (p_aux_write)
    else $error("aux control bits not written");

  // current code takes only the defined steps, else keeps its value
  property p_cur_code;
    clk_en && wr_at(host_req, ADDR_AUX)
      |=> excitation_current_code ==
          (($past(host_req.wdata[AUX_CUR_LSB +: CUR_W]) <= CUR_CODE_MAX) ?
           $past(host_req.wdata[AUX_CUR_LSB +: CUR_W]) : $past(excitation_current_code));
  endproperty
  a_cur_code: assert property (p_cur_code)
    else $error("excitation current code wrong");

  // mode in effect copies the request when the supply confirms
  property p_pwr_now;
    clk_en && power_ack && !take_full |=> st.pwr_now == $past(power_mode_req);
  endproperty
  a_pwr_now: assert property (p_pwr_now)
    else $error("mode in effect not updated");

  // main scenarios
  c_full_reset: cover property (take_full ##1 calibration_reset);
  c_stale_read: cover property (clk_en && host_req.rd && res_hit && st.avail
                                ##[1:8] st.stale);
  c_pwr_change: cover property (power_ack && clk_en ##1 $changed(st.pwr_now));
  c_new_result: cover property (conv_done && clk_en ##1 st.avail);
endmodule // adccs_regs
`default_nettype wire

// ---- testbench/adccs_core_model.sv ----
// Purpose: analog core stand-in, power controller and converter
// Assumes: same clock as the register block
// Notes:   result bus inverts its word every cycle outside the done pulse
`timescale 1ns/100ps
`default_nettype none
module adccs_core_model (
  input  wire logic                        core_clk,       // 200 MHz
  input  wire logic                        rst_n,          // sync reset
  input  wire logic [adccs_pkg::PWR_W-1:0] power_mode_req, // mode asked for
  input  wire logic [7:0]                  ack_delay,      // settling cycles
  input  wire logic                        fire,           // bench wants a result
  input  wire logic [adccs_pkg::RES_W-1:0] value,          // result to deliver
  output logic                             power_ack,      // mode applied
  output logic                             conv_done,      // result pulse
  output logic [adccs_pkg::RES_W-1:0]      conv_result     // result word
);
  import adccs_pkg::*;
  logic [PWR_W-1:0] last_req; // mode seen last
  logic [7:0]       wait_cnt; // settling countdown
  logic             busy;     // change in progress
  // power controller: a real supply settles late, so ack after a delay
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      last_req  <= '0;
      wait_cnt  <= 8'h00;
      busy      <= 1'b0;
      power_ack <= 1'b0;
    end else begin
      power_ack <= 1'b0;
      if (power_mode_req != last_req) begin
        last_req <= power_mode_req;
        wait_cnt <= ack_delay;
        busy     <= 1'b1;
      end else if (busy && wait_cnt == 8'h00) begin
        busy      <= 1'b0;
        power_ack <= 1'b1;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 8'h01;
      end
    end
  end
  // converter: stale data alternates between the inverse of the last word and the word itself
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv_done   <= 1'b0;
      conv_result <= '0;
    end else begin
      conv_done   <= fire;
      conv_result <= fire ? value : ~conv_result;
    end
  end
endmodule // adccs_core_model
`default_nettype wire

// ---- testbench/adccs_regs_test.sv ----
// Purpose: self-checking bench of the control/status registers
// Assumes: one access at a time through the register port
// Notes:   reserved bits are always written as zero
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module adccs_regs_test;
  import adccs_pkg::*;
  logic              core_clk;     // bench clock
  logic              rst_n;        // sync reset
  logic              clk_en;       // clock enable
  adccs_req_t        host_req;     // register access
  logic [7:0]        rd_data;      // read byte
  logic              rd_valid;     // read strobe
  logic              conv_done;    // from model
  logic [RES_W-1:0]  conv_result;  // from model
  logic              power_ack;    // from model
  logic              scan_pend;    // scan busy level
  logic              ser_en;       // serial reset enable
  logic [PWR_W-1:0]  pwr_req;      // requested mode
  logic              restart;      // restart pulse
  logic              full_rst;     // full reset pulse
  logic              cal_rst;      // coeff restore pulse
  logic              byp;          // detect bypass
  logic              sel_ext;      // external clock
  logic [CUR_W-1:0]  cur;          // current code
  logic [7:0]        ack_delay;    // model settling
  logic              fire;         // result request
  logic [RES_W-1:0]  value;        // result word
  logic [PWR_W-1:0]  codes [3];    // power codes to walk
  int                mismatches;   // failed compares
  int                num_checks;   // all compares

  adccs_regs adccs_regs_i (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .host_req(host_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .conv_done(conv_done),
    .conv_result(conv_result), .power_ack(power_ack), .scan_update_pending(scan_pend),
    .serial_reset_enable(ser_en), .power_mode_req(pwr_req),
    .conversion_restart(restart), .full_reset_pulse(full_rst),
    .calibration_reset(cal_rst), .clock_detect_bypass(byp),
    .clock_select_ext(sel_ext), .excitation_current_code(cur)
  );
  adccs_core_model adccs_core_model_i (
    .core_clk(core_clk), .rst_n(rst_n), .power_mode_req(pwr_req),
    .ack_delay(ack_delay), .fire(fire), .value(value), .power_ack(power_ack),
    .conv_done(conv_done), .conv_result(conv_result)
  );

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // one write; outputs settled on return
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_req <= {1'b1, 1'b0, a, d};
    @(posedge core_clk);
    host_req <= '0;
    #1;
  endtask

  // one read with a bounded wait for the strobe, then compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    int n;
    @(posedge core_clk);
    host_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    host_req <= '0;
    n = 0;
    #1;
    while (rd_valid !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 8) begin
      mismatches++;
      $display("mismatch at %0t: no read strobe", $time);
    end
    `CHK(rd_data, e);
    // the strobe stands for one cycle only
    @(posedge core_clk);
    #1;
    `CHK(rd_valid, 1'b0);
  endtask

  task automatic test_end(input string s);
    $display("test %s finished", s);
  endtask

  // verdict; also reached from the watchdog
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog: tests need about 74 us
  initial begin
    #300000;
    mismatches++;
    $display("mismatch at %0t: run hung", $time);
    end_sim();
  end

  // main sequence
  initial begin
    host_req   = '0;
    rst_n      = 1'b0;
    clk_en     = 1'b1;
    scan_pend  = 1'b0;
    fire       = 1'b0;
    value      = '0;
    ack_delay  = 8'h00;
    mismatches = 0;
    num_checks = 0;
    codes      = '{PWR_DOWN, PWR_STANDBY, PWR_ACTIVE};
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rchk(ADDR_SER_RESET, 8'h00);
    rchk(ADDR_POWER, 8'h00);
    rchk(ADDR_AUX, 8'h00);
    rchk(ADDR_AVAIL, AVAIL_NONE);
    rchk(ADDR_CHAN_STAT, 8'h00);
    rchk(8'h05, 8'h00);
    test_end("reset values");
    // sticky enable, wrong reset code, real reset
    wr(ADDR_SER_RESET, 8'h01);
    `CHK(ser_en, 1'b1);
    wr(ADDR_SER_RESET, 8'h00);
    rchk(ADDR_SER_RESET, 8'h01);
    wr(ADDR_RESET_CTRL, 8'hc2);
    `CHK(full_rst, 1'b0);
    rchk(ADDR_SER_RESET, 8'h01);
    wr(ADDR_RESET_CTRL, FULL_RESET_CODE);
    `CHK(full_rst, 1'b1);
    rchk(ADDR_SER_RESET, 8'h00);
    wr(ADDR_SER_RESET, 8'h01);
    rchk(ADDR_SER_RESET, 8'h01);
    test_end("serial reset");
    // every power code, one with a slow supply
    for (int i = 0; i < 3; i++) begin
      ack_delay <= (i == 1) ? 8'h28 : 8'h00;
      wr(ADDR_POWER, {6'h00, codes[i]});
      `CHK(pwr_req, codes[i]);
      if (i == 1) begin
        rchk(ADDR_POWER, {6'h00, codes[0]});
      end
      repeat (60) @(posedge core_clk);
      rchk(ADDR_POWER, {6'h00, codes[i]});
    end
    wr(ADDR_POWER, 8'h02);
    `CHK(pwr_req, PWR_ACTIVE);
    rchk(ADDR_POWER, 8'h00);
    test_end("power");
    wr(ADDR_RESTART, 8'h01);
    `CHK(restart, 1'b1);
    wr(ADDR_RESTART, 8'h00);
    `CHK(restart, 1'b0);
    test_end("restart");
    // aux fields, refused current code, calibration policy
    wr(ADDR_AUX, 8'h3a);
    `CHK({byp, sel_ext, cur}, 6'h3a);
    rchk(ADDR_AUX, 8'h3a);
    wr(ADDR_AUX, 8'h1b);
    `CHK({byp, sel_ext, cur}, 6'h0a);
    rchk(ADDR_AUX, 8'h1a);
    // frozen block ignores a write
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(ADDR_AUX, 8'h05);
    `CHK(cur, 4'ha);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rchk(ADDR_AUX, 8'h1a);
    wr(ADDR_AUX, 8'h40);
    wr(ADDR_RESET_CTRL, FULL_RESET_CODE);
    `CHK(cal_rst, 1'b1);
    wr(ADDR_RESET_CTRL, FULL_RESET_CODE);
    `CHK(cal_rst, 1'b0);
    test_end("aux");
    // result bytes, stale flag, scan pending
    @(posedge core_clk);
    fire  <= 1'b1;
    value <= 24'h80_1234;
    @(posedge core_clk);
    fire <= 1'b0;
    rchk(ADDR_AVAIL, AVAIL_READY);
    rchk(ADDR_RES_HI, 8'h80);
    rchk(ADDR_RES_MID, 8'h12);
    rchk(ADDR_RES_LO, 8'h34);
    rchk(ADDR_CHAN_STAT, 8'h00);
    rchk(ADDR_AVAIL, AVAIL_NONE);
    repeat (14400) @(posedge core_clk);
    rchk(ADDR_RES_HI, 8'h80);
    scan_pend <= 1'b1;
    rchk(ADDR_CHAN_STAT, 8'h03);
    test_end("result");
    end_sim();
  end
endmodule // adccs_regs_test
`default_nettype wire
